// [rtl/ebv_pkg.sv]
// Constants and types of the expansion bus visibility block
// Operation
// - Stretch lengthens data phase, never address phase
// - Steer bytes: 8, 16, swapped, or assembled
// - Visibility in wide, special test, emulation narrow
// - No visibility in single-chip, peripheral, normal narrow
// - Visibility switched on by mode register bit
// - Invisible internal cycle: clock low, read high
// - Address pins always driven
// - Debug cycle: read high, data held, address updated
// - Idle cycle: read high, pins held when visibility is on
// - Secured: visibility enable ignored
// - Secured: pipe status shows zeroes
// - Secured: mode select bits not writable
// - After stop, bus interface takes no new transfers
// - Single-chip: address outputs held quiet
// - Fourteen byte registers, five reserved locations
// - Stretch adds 0 to 3 bus periods
// - Strobe, address bit zero, read encode access
// - Stretch enable: clock high stretched, low keeps clock toggling
package ebv_pkg;
	localparam logic [2:0] MODE_SPEC_SINGLE = 3'h0;
	localparam logic [2:0] MODE_EMUL_NARROW = 3'h1;
	localparam logic [2:0] MODE_SPEC_TEST = 3'h2;
	localparam logic [2:0] MODE_EMUL_WIDE = 3'h3;
	localparam logic [2:0] MODE_NORM_SINGLE = 3'h4;
	localparam logic [2:0] MODE_NORM_NARROW = 3'h5;
	localparam logic [2:0] MODE_SPEC_PERIPH = 3'h6;
	localparam logic [2:0] MODE_NORM_WIDE = 3'h7;
	localparam int REG_COUNT = 14;
	localparam int RSVD_COUNT = 5;
	localparam logic [4:0] REG_LOCS = 5'h13;
	localparam logic [4:0] REG_IDX_MODE = 5'h0B;
	localparam logic [4:0] REG_IDX_CTL = 5'h0E;
	localparam int MODE_SEL_MSB = 7;
	localparam int MODE_SEL_LSB = 5;
	localparam int MODE_INTERNAL_VISIBILITY_ENABLE_BIT = 3;
	localparam logic [7:0] MODE_SEL_MASK = 8'hE0;
	localparam int CTL_CLOCK_STRETCH_ENABLE_BIT = 0;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] CTL_RST = 8'h01;
	localparam logic [1:0] KIND_EXT = 2'h0;
	localparam logic [1:0] KIND_INT = 2'h1;
	localparam logic [1:0] KIND_DBG = 2'h2;
	localparam logic [1:0] KIND_IDLE = 2'h3;
	localparam int LINK_PER_BUS = 2;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_STRETCH, ST_DONE} ebv_state_t;
endpackage

// [rtl/ebv_bus.sv]
// Expansion bus data interface and internal visibility control
`timescale 1ns/1ps
module ebv_bus import ebv_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic reg_wr,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic secure,
	input wire logic stop,
	input wire logic pipe_en,
	input wire logic [1:0] pipe_in,
	output logic [1:0] instruction_pipe_status,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_kind,
	input wire logic [15:0] req_addr,
	input wire logic req_we,
	input wire logic req_size16,
	input wire logic [15:0] req_wdata,
	input wire logic [1:0] stretch_sel,
	output logic rsp_valid,
	output logic [15:0] rsp_rdata,
	output logic [15:1] bus_addr,
	output logic address_bit_zero,
	output logic bus_clock_output,
	output logic rw_out,
	output logic low_byte_strobe_n,
	output logic [15:0] data_out,
	output logic data_oe_n,
	input wire logic [15:0] data_in
);
	logic [7:0] mode_q, ctl_q, reg_rdata_q;
	logic [1:0] pipe_q;
	logic vis_q, ready_q, busy_q, req_tog_q, rsp_valid_q;
	logic ack_s1, ack_s2, ack_s3;
	logic [15:0] rsp_rdata_q;
	// Link-side answer, read here only behind the toggle handshake
	logic l_ack_tog_q;
	logic [15:0] l_rd_q;
	logic [1:0] h_kind, h_str;
	logic [15:0] h_addr, h_wd;
	logic h_we, h_sz16, h_vis, h_clock_stretch_enable, h_single, h_narrow;

	wire mode_hit = reg_wr && reg_addr == REG_IDX_MODE;
	wire ctl_hit = reg_wr && reg_addr == REG_IDX_CTL;
	// Secured parts keep the mode select field
	wire [7:0] mode_wr_val = secure ? ((reg_wdata & ~MODE_SEL_MASK) | (mode_q & MODE_SEL_MASK))
		: reg_wdata;
	// Reserved and foreign locations read zero, writes dropped
	wire [7:0] rd_mux = (reg_addr == REG_IDX_MODE) ? mode_q :
		(reg_addr == REG_IDX_CTL) ? ctl_q : 8'h00;
	wire [2:0] op_mode = mode_q[MODE_SEL_MSB:MODE_SEL_LSB];
	wire vis_allowed = op_mode == MODE_NORM_WIDE || op_mode == MODE_EMUL_WIDE ||
		op_mode == MODE_SPEC_TEST || op_mode == MODE_EMUL_NARROW;
	wire vis_on = mode_q[MODE_INTERNAL_VISIBILITY_ENABLE_BIT] && vis_allowed && !secure;
	wire is_single = op_mode == MODE_SPEC_SINGLE || op_mode == MODE_NORM_SINGLE;
	wire is_narrow = op_mode == MODE_EMUL_NARROW || op_mode == MODE_NORM_NARROW;
	wire take = req_valid && ready_q;
	wire ack_evt = ack_s2 ^ ack_s3;
	// Stop freezes new transfers; one in flight still completes
	wire ready_d = !stop && !take && !(busy_q && !ack_evt);
	wire [1:0] pipe_d = (pipe_en && !secure) ? pipe_in : 2'h0;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mode_q <= MODE_RST;
			ctl_q <= CTL_RST;
		end else begin
			if (mode_hit)
				mode_q <= mode_wr_val;
			if (ctl_hit)
				ctl_q <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata_q <= 8'h00;
			pipe_q <= 2'h0;
			vis_q <= 1'b0;
			ready_q <= 1'b0;
			busy_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_rdata_q <= 16'h0000;
		end else begin
			reg_rdata_q <= rd_mux;
			pipe_q <= pipe_d;
			vis_q <= vis_on;
			ready_q <= ready_d;
			busy_q <= take || (busy_q && !ack_evt);
			rsp_valid_q <= ack_evt;
			if (ack_evt)
				rsp_rdata_q <= l_rd_q;
		end
	end

	// Request fields stay still until the link answers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			req_tog_q <= 1'b0;
			{h_kind, h_str, h_addr, h_wd} <= 36'h0_0000_0000;
			{h_we, h_sz16, h_vis, h_clock_stretch_enable, h_single, h_narrow} <= 6'h00;
		end else if (take) begin
			req_tog_q <= ~req_tog_q;
			{h_kind, h_str, h_addr, h_wd} <= {req_kind, stretch_sel, req_addr, req_wdata};
			{h_we, h_sz16, h_vis} <= {req_we, req_size16, vis_q};
			{h_clock_stretch_enable, h_single, h_narrow} <= {ctl_q[CTL_CLOCK_STRETCH_ENABLE_BIT], is_single, is_narrow};
		end
	end

	always_ff @(posedge sys_clk) begin
		ack_s1 <= l_ack_tog_q;
		ack_s2 <= ack_s1;
		ack_s3 <= ack_s2;
	end

	assign reg_rdata = reg_rdata_q;
	assign instruction_pipe_status = pipe_q;
	assign req_ready = ready_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_rdata = rsp_rdata_q;

	// Link domain
	logic lrst_s1, lrst_q, rq_s1, rq_s2, rq_s3;
	logic [15:0] din_s1, din_s2;
	ebv_state_t state_q, state_d;
	logic [2:0] str_cnt_q;
	logic beat_q;
	// Pipelines that wait out the pin synchroniser before capture and answer
	logic [1:0] cap_q, cbeat_q, done_q;
	logic bclk_q, rw_q, strb_q, doe_n_q;
	logic [15:0] addr_q, dout_q;

	always_ff @(posedge link_clk) begin
		lrst_s1 <= rst;
		lrst_q <= lrst_s1;
		rq_s1 <= req_tog_q;
		rq_s2 <= rq_s1;
		rq_s3 <= rq_s2;
		din_s1 <= data_in;
		din_s2 <= din_s1;
	end

	wire start = rq_s2 ^ rq_s3;
	// Invisible internal, debug and idle cycles never look like accesses
	wire show = h_kind == KIND_EXT || (h_kind == KIND_INT && h_vis);
	wire dbg_upd = h_kind == KIND_DBG && h_vis;
	wire idle_hold = h_kind == KIND_IDLE && h_vis;
	wire two_beat = h_narrow && h_sz16;
	wire more_beat = show && two_beat && !beat_q;
	wire [15:0] cur_addr = h_addr + {15'h0000, beat_q};
	wire cur_sz = h_sz16 && !h_narrow;
	wire strb_val = cur_sz ? cur_addr[0] : ~cur_addr[0];
	wire [15:0] wlane_wide = cur_sz ? (cur_addr[0] ? {h_wd[7:0], h_wd[15:8]} : h_wd) :
		(cur_addr[0] ? {8'h00, h_wd[7:0]} : {h_wd[7:0], 8'h00});
	wire [7:0] wbyte_narrow = two_beat ? (beat_q ? h_wd[7:0] : h_wd[15:8]) : h_wd[7:0];
	wire [15:0] wlane = h_narrow ? {wbyte_narrow, 8'h00} : wlane_wide;
	wire [15:0] rcap_wide = cur_sz ?
		(cur_addr[0] ? {din_s2[7:0], din_s2[15:8]} : din_s2) :
		(cur_addr[0] ? {8'h00, din_s2[7:0]} : {8'h00, din_s2[15:8]});
	wire [15:0] rcap_narrow = two_beat ?
		(cbeat_q[1] ? {l_rd_q[15:8], din_s2[15:8]} : {din_s2[15:8], 8'h00}) :
		{8'h00, din_s2[15:8]};
	wire [15:0] rcap = h_narrow ? rcap_narrow : rcap_wide;
	// Only external cycles are stretched; visible internal ones keep bus speed
	wire ext_cyc = h_kind == KIND_EXT;
	// Data phase ends at the falling edge, after any stretch
	wire end_cycle = (state_q == ST_DATA && (!ext_cyc || h_str == 2'h0)) ||
		(state_q == ST_STRETCH && str_cnt_q == 3'h0);
	wire stretch_clk = show && (h_clock_stretch_enable || !bclk_q);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (start)
					state_d = ST_ADDR;
			end
			ST_ADDR: state_d = ST_DATA;
			ST_DATA, ST_STRETCH: begin
				if (end_cycle)
					state_d = more_beat ? ST_ADDR : ST_DONE;
				else
					state_d = ST_STRETCH;
			end
			ST_DONE: state_d = ST_IDLE;
		endcase
	end

	wire in_addr = state_q == ST_ADDR;
	wire bclk_d = (state_q == ST_DATA) ? show :
		(state_q == ST_STRETCH) ? stretch_clk : 1'b0;
	wire rw_d = in_addr ? (show ? ~h_we : 1'b1) :
		(state_q == ST_IDLE) ? 1'b1 : rw_q;
	wire [15:0] addr_d = !in_addr ? addr_q : h_single ? 16'h0000 :
		idle_hold ? addr_q : cur_addr;
	wire strb_d = (in_addr && (show || dbg_upd)) ? strb_val : strb_q;
	wire [15:0] dout_d = (in_addr && show && h_we) ? wlane : dout_q;
	wire doe_n_d = (in_addr && show) ? ~h_we :
		(state_q == ST_DONE && show) ? 1'b1 : doe_n_q;
	wire [2:0] str_load = {h_str, 1'b0};

	always_ff @(posedge link_clk) begin
		if (lrst_q) begin
			state_q <= ST_IDLE;
			str_cnt_q <= 3'h0;
			beat_q <= 1'b0;
			l_ack_tog_q <= 1'b0;
			l_rd_q <= 16'h0000;
			cap_q <= 2'h0;
			cbeat_q <= 2'h0;
			done_q <= 2'h0;
		end else begin
			state_q <= state_d;
			str_cnt_q <= in_addr ? str_load : str_cnt_q - 3'h1;
			beat_q <= (state_q == ST_IDLE) ? 1'b0 : (end_cycle && more_beat) ? 1'b1 : beat_q;
			// Beat data reaches din_s2 two edges after the data phase ends
			cap_q <= {cap_q[0], end_cycle && show && !h_we};
			cbeat_q <= {cbeat_q[0], beat_q};
			done_q <= {done_q[0], state_q == ST_DONE};
			// Answer only after the last capture, so the word is settled
			if (done_q[1])
				l_ack_tog_q <= ~l_ack_tog_q;
			if (start)
				l_rd_q <= 16'h0000;
			else if (cap_q[1])
				l_rd_q <= rcap;
		end
	end

	always_ff @(posedge link_clk) begin
		if (lrst_q) begin
			{bclk_q, rw_q, strb_q, doe_n_q} <= 4'h7;
			addr_q <= 16'h0000;
			dout_q <= 16'h0000;
		end else begin
			{bclk_q, rw_q, strb_q, doe_n_q} <= {bclk_d, rw_d, strb_d, doe_n_d};
			addr_q <= addr_d;
			dout_q <= dout_d;
		end
	end

	assign bus_addr = addr_q[15:1];
	assign address_bit_zero = addr_q[0];
	assign bus_clock_output = bclk_q;
	assign rw_out = rw_q;
	assign low_byte_strobe_n = strb_q;
	assign data_out = dout_q;
	assign data_oe_n = doe_n_q;

	// Checks
	logic [2:0] str_seen_q;
	always_ff @(posedge link_clk) begin
		if (lrst_q || state_q != ST_STRETCH)
			str_seen_q <= 3'h0;
		else
			str_seen_q <= str_seen_q + 3'h1;
	end

	sequence s_addr_phase;
		state_q == ST_ADDR ##1 (state_q == ST_DATA && !bus_clock_output);
	endsequence

	chk_addr_unstretched: assert property (@(posedge link_clk) disable iff (lrst_q)
		state_q == ST_ADDR |-> s_addr_phase ##1 (bus_clock_output == show))
		else $error("address phase not one low link cycle");
	chk_stretch_length: assert property (@(posedge link_clk) disable iff (lrst_q)
		(state_q == ST_STRETCH && end_cycle) |-> str_seen_q + 3'h1 == {h_str, 1'b0})
		else $error("stretch length differs from setting");
	chk_invis_clock_low: assert property (@(posedge link_clk) disable iff (lrst_q)
		(state_q == ST_DATA && !show) |=> !bus_clock_output && rw_out)
		else $error("invisible cycle showed a clock or write");
	chk_debug_data_held: assert property (@(posedge link_clk) disable iff (lrst_q)
		(state_q == ST_ADDR && dbg_upd) |=> rw_out && $stable(data_out)
		&& address_bit_zero == cur_addr[0])
		else $error("debug cycle changed data or kept address");
	chk_idle_pins_held: assert property (@(posedge link_clk) disable iff (lrst_q)
		(state_q == ST_ADDR && idle_hold) |=> $stable(bus_addr) && $stable(low_byte_strobe_n)
		&& rw_out)
		else $error("idle cycle moved address or strobe");
	chk_clock_stretch_enable_clock_high: assert property (@(posedge link_clk) disable iff (lrst_q)
		(state_q == ST_STRETCH && show && h_clock_stretch_enable) |=> bus_clock_output)
		else $error("clock fell during stretch");
	chk_single_addr_quiet: assert property (@(posedge link_clk) disable iff (lrst_q)
		(state_q == ST_ADDR && h_single) |=> {bus_addr, address_bit_zero} == 16'h0000)
		else $error("address toggled in single-chip mode");
	chk_strobe_encoding: assert property (@(posedge link_clk) disable iff (lrst_q)
		(state_q == ST_ADDR && show && !h_narrow) |=>
		low_byte_strobe_n == (h_sz16 ? address_bit_zero : !address_bit_zero))
		else $error("strobe does not match access type");
	chk_secure_pipe_zero: assert property (@(posedge sys_clk) disable iff (rst)
		secure |=> instruction_pipe_status == 2'h0)
		else $error("pipe status leaked while secured");
	chk_mode_sel_locked: assert property (@(posedge sys_clk) disable iff (rst)
		(secure && mode_hit) |=> $stable(mode_q[MODE_SEL_MSB:MODE_SEL_LSB]))
		else $error("mode select written while secured");
	chk_vis_denied: assert property (@(posedge sys_clk) disable iff (rst)
		(secure || !vis_allowed) |=> !vis_q)
		else $error("visibility on where not allowed");
	chk_stop_no_take: assert property (@(posedge sys_clk) disable iff (rst)
		stop |=> !req_ready)
		else $error("request accepted while stopped");
	chk_internal_no_stretch: assert property (@(posedge link_clk) disable iff (lrst_q)
		(state_q == ST_DATA && !ext_cyc) |=> state_q != ST_STRETCH)
		else $error("internal cycle was stretched");
endmodule

// [verif/ebv_mem_model.sv]
// Behavioural external memory hanging on the expansion bus pins
`timescale 1ns/1ps
module ebv_mem_model (
	input wire logic link_clk,
	input wire logic [15:1] bus_addr,
	input wire logic bus_clock_output,
	input wire logic rw_out,
	input wire logic [15:0] data_out,
	input wire logic data_oe_n,
	output logic [15:0] data_in
);
	logic [15:0] mem [0:15];
	logic [15:0] last_q = 16'h0000;
	logic clk_q = 1'b0;
	wire rd_sel = rw_out && data_oe_n;
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = {4'hA, 4'(i), 4'h5, 4'(i)};
		end
	end
	// Drive as soon as the address settles; released lines toggle, never hold
	assign data_in = rd_sel ? mem[bus_addr[4:1]] : ~last_q;
	always @(posedge link_clk) begin
		last_q <= data_in;
		clk_q <= bus_clock_output;
		// Only a falling clock with write level is an access
		if (clk_q && !bus_clock_output && !rw_out) begin
			mem[bus_addr[4:1]] <= data_out;
		end
	end
endmodule

// [verif/ebv_bus_tb.sv]
// Self-checking bench of the expansion bus visibility block
`timescale 1ns/1ps
module ebv_bus_tb;
	import ebv_pkg::*;
	logic sys_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic secure = 1'b0;
	logic stop = 1'b0;
	logic pipe_en = 1'b1;
	logic [1:0] pipe_in = 2'h3;
	logic req_valid = 1'b0;
	logic [1:0] req_kind = 2'h0;
	logic [15:0] req_addr = 16'h0000;
	logic req_we = 1'b0;
	logic req_size16 = 1'b1;
	logic [15:0] req_wdata = 16'h0000;
	logic [1:0] stretch_sel = 2'h0;
	logic [7:0] reg_rdata;
	logic [1:0] instruction_pipe_status;
	logic req_ready;
	logic rsp_valid;
	logic [15:0] rsp_rdata;
	logic [15:1] bus_addr;
	logic address_bit_zero;
	logic bus_clock_output;
	logic rw_out;
	logic low_byte_strobe_n;
	logic [15:0] data_out;
	logic data_oe_n;
	logic [15:0] data_in;
	int checks = 0;
	int mismatches = 0;
	int cyc = 0;
	int hi_cnt = 0;
	logic rw_low = 1'b0;
	logic strb = 1'b1;
	ebv_bus i_dut (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .secure(secure),
		.stop(stop), .pipe_en(pipe_en), .pipe_in(pipe_in),
		.instruction_pipe_status(instruction_pipe_status), .req_valid(req_valid),
		.req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr), .req_we(req_we),
		.req_size16(req_size16), .req_wdata(req_wdata), .stretch_sel(stretch_sel),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus_addr(bus_addr),
		.address_bit_zero(address_bit_zero), .bus_clock_output(bus_clock_output),
		.rw_out(rw_out), .low_byte_strobe_n(low_byte_strobe_n), .data_out(data_out),
		.data_oe_n(data_oe_n), .data_in(data_in));
	ebv_mem_model i_mem (.link_clk(link_clk), .bus_addr(bus_addr),
		.bus_clock_output(bus_clock_output), .rw_out(rw_out), .data_out(data_out),
		.data_oe_n(data_oe_n), .data_in(data_in));
	always #10 sys_clk = ~sys_clk;
	initial begin
		#7;
		forever #24 link_clk = ~link_clk;
	end
	always @(posedge link_clk) begin
		if (bus_clock_output === 1'b1) begin
			hi_cnt++;
			strb = low_byte_strobe_n;
		end
		if (rw_out === 1'b0) rw_low = 1'b1;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [4:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rreg(input logic [4:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		reg_addr = a;
		repeat (2) @(negedge sys_clk);
		check({8'h00, reg_rdata}, {8'h00, exp});
	endtask
	task automatic xfer(input logic [1:0] k, input logic [15:0] a, input logic we,
		input logic sz, input logic [15:0] wd, input logic [1:0] st);
		int n;
		n = 0;
		@(negedge sys_clk);
		hi_cnt = 0;
		rw_low = 1'b0;
		req_valid = 1'b1;
		req_kind = k;
		req_addr = a;
		req_we = we;
		req_size16 = sz;
		req_wdata = wd;
		stretch_sel = st;
		while (req_ready !== 1'b1 && n < 100) begin
			@(negedge sys_clk);
			n++;
		end
		@(negedge sys_clk);
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 300) begin
			@(negedge sys_clk);
			n++;
		end
		check(16'(n < 300), 16'h0001);
	endtask
	task automatic t_regs;
		rreg(REG_IDX_MODE, MODE_RST);
		rreg(REG_IDX_CTL, CTL_RST);
		wreg(5'h05, 8'hFF);
		rreg(5'h05, 8'h00);
	endtask
	task automatic t_secure;
		wreg(REG_IDX_MODE, 8'hE8);
		secure = 1'b1;
		wreg(REG_IDX_MODE, 8'h68);
		rreg(REG_IDX_MODE, 8'hE8);
		check({14'h0, instruction_pipe_status}, 16'h0000);
		xfer(KIND_INT, 16'h0040, 1'b0, 1'b1, 16'h0000, 2'h0);
		check(16'(hi_cnt), 16'h0000);
		secure = 1'b0;
		repeat (2) @(negedge sys_clk);
		check({14'h0, instruction_pipe_status}, 16'h0003);
		xfer(KIND_INT, 16'h0040, 1'b0, 1'b1, 16'h0000, 2'h0);
		check(16'(hi_cnt), 16'h0001);
	endtask
	task automatic t_ext;
		wreg(REG_IDX_MODE, {MODE_NORM_WIDE, 5'h00});
		xfer(KIND_EXT, 16'h0004, 1'b1, 1'b1, 16'h1234, 2'h0);
		check({15'h0, rw_low}, 16'h0001);
		check({15'h0, data_oe_n}, 16'h0001);
		xfer(KIND_EXT, 16'h0004, 1'b0, 1'b1, 16'h0000, 2'h0);
		check(rsp_rdata, 16'h1234);
		check({14'h0, strb, address_bit_zero}, 16'h0000);
		xfer(KIND_EXT, 16'h0007, 1'b0, 1'b0, 16'h0000, 2'h0);
		check({8'h00, rsp_rdata[7:0]}, 16'h0053);
		check({14'h0, strb, address_bit_zero}, 16'h0001);
		for (int s = 0; s < 4; s++) begin
			xfer(KIND_EXT, 16'h0006, 1'b0, 1'b1, 16'h0000, 2'(s));
			check(16'(hi_cnt), 16'(1 + 2 * s));
			check(rsp_rdata, 16'hA353);
		end
		wreg(REG_IDX_CTL, 8'h00);
		xfer(KIND_EXT, 16'h0006, 1'b0, 1'b1, 16'h0000, 2'h2);
		check(16'(hi_cnt), 16'h0003);
		wreg(REG_IDX_CTL, CTL_RST);
		wreg(REG_IDX_MODE, {MODE_EMUL_NARROW, 5'h00});
		xfer(KIND_EXT, 16'h0007, 1'b0, 1'b1, 16'h0000, 2'h0);
		check(rsp_rdata, 16'hA3A4);
		check(16'(hi_cnt), 16'h0002);
	endtask
	task automatic vis(input logic [7:0] m, input logic [1:0] k, input logic we, input int hi);
		wreg(REG_IDX_MODE, m);
		xfer(k, 16'h0052, we, 1'b1, 16'h5AA5, 2'h1);
		check(16'(hi_cnt), 16'(hi));
	endtask
	task automatic t_vis;
		vis(8'hE0, KIND_INT, 1'b1, 0);
		check({15'h0, rw_low}, 16'h0000);
		check({1'b0, bus_addr}, 16'h0029);
		vis(8'hE8, KIND_INT, 1'b0, 1);
		vis(8'h68, KIND_INT, 1'b0, 1);
		vis(8'h28, KIND_INT, 1'b0, 2);
		vis(8'hA8, KIND_INT, 1'b0, 0);
		vis(8'h88, KIND_INT, 1'b0, 0);
		check({1'b0, bus_addr}, 16'h0000);
		vis(8'hC8, KIND_INT, 1'b0, 0);
	endtask
	task automatic t_dbg;
		wreg(REG_IDX_MODE, 8'hE8);
		xfer(KIND_DBG, 16'h0012, 1'b1, 1'b1, 16'hFFFF, 2'h0);
		check({15'h0, rw_low}, 16'h0000);
		check({1'b0, bus_addr}, 16'h0009);
		check(data_out, 16'h1234);
		xfer(KIND_IDLE, 16'h0022, 1'b1, 1'b1, 16'hFFFF, 2'h0);
		check({15'h0, rw_low}, 16'h0000);
		check({1'b0, bus_addr}, 16'h0009);
		check(data_out, 16'h1234);
	endtask
	task automatic t_stop;
		@(negedge sys_clk);
		stop = 1'b1;
		repeat (2) @(negedge sys_clk);
		check({15'h0, req_ready}, 16'h0000);
		stop = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
	initial begin
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		t_regs();
		t_secure();
		t_ext();
		t_vis();
		t_dbg();
		t_stop();
		test_done();
	end
endmodule
